// ---- hdl/mipu_pkg.sv ----
package mipu_pkg;
  localparam int NUM_SRC = 8;
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [2:0] LVL_MAX = 3'h7;
  localparam logic [19:0] INFO_ADDR = 20'h00000;
  localparam int ENTRY_NS = 160;
  localparam int CLK_NS = 8;
  localparam int ENTRY_CYC = ENTRY_NS / CLK_NS;
  localparam logic [4:0] ENTRY_LAST = 5'(ENTRY_CYC - 1);
  localparam logic [5:0] SWI_LO = 6'h20;
  // flag register bit positions
  localparam int FLG_D = 2;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam logic [15:0] FLG_RST = 16'h0000;
  localparam logic [3:0] STEP_RD = 4'h0;
  localparam logic [3:0] STEP_W0 = 4'h3;
  localparam logic [3:0] STEP_W1 = 4'h5;
  localparam logic [3:0] STEP_W2 = 4'h7;
  localparam logic [3:0] STEP_W3 = 4'h9;
  localparam int AW = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LEVEL = 8'h04;
  localparam logic [7:0] OFF_PEND = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_SAVE = 8'h10;
  typedef enum logic [1:0] {SPC_NONE, SPC_WDT, SPC_LOW} mipu_spc_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
    logic rd;
    logic wr;
  } mipu_bus_t;
endpackage

// ---- hdl/mipu_top.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module mipu_top
  import mipu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic instr_done,
  input wire logic instr_suspendable,
  input wire logic swi_exec,
  input wire logic [5:0] swi_num,
  input wire logic spc_wdt,
  input wire logic spc_low,
  input wire logic ret_exec,
  input wire logic [15:0] ret_flags,
  input wire logic [19:0] ret_pc,
  input wire logic [19:0] cur_pc,
  input wire logic [19:0] sp,
  input wire logic [19:0] vec_pc,
  output logic entry_busy,
  output logic entry_start,
  output logic routine_go,
  output logic [5:0] entry_num,
  output logic [15:0] flags,
  output logic [2:0] proc_level,
  output logic [19:0] pc_load,
  output mipu_bus_t cpu_bus,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [NUM_SRC-1:0] pend_q, req_d1_q;
  logic [2:0] lvl_q [NUM_SRC];
  logic [15:0] flg_q, tmp_q;
  logic [2:0] ipl_q, acc_lvl_q;
  logic [4:0] cnt_q;
  logic busy_q, start_q, go_q;
  logic [5:0] num_q;
  logic swi_q;
  logic [2:0] src_q;
  mipu_spc_t spc_q;
  mipu_bus_t bus_q;
  logic [19:0] pc_q, savepc_q;
  logic [AW-1:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_have_q, w_have_q, bv_q, arr_q, rv_q;
  logic [31:0] rd_q;
  logic [1:0] rresp_q;

  function automatic logic lvl_ok(input logic [2:0] l, input logic [2:0] p);
    lvl_ok = (l != LVL_OFF) && (l > p);
  endfunction

  // arbitration: highest level, lowest index on ties
  logic [2:0] best_lvl;
  logic [2:0] best_idx;
  logic best_any;
  always_comb
  begin
    best_lvl = LVL_OFF;
    best_idx = 3'h0;
    best_any = 1'b0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (pend_q[i] && lvl_ok(lvl_q[i], ipl_q) &&
          (!best_any || lvl_q[i] > best_lvl))
      begin
        best_any = 1'b1;
        best_lvl = lvl_q[i];
        best_idx = 3'(i);
      end
    end
  end

  wire mask_ok = flg_q[FLG_I];
  wire at_boundary = instr_done || instr_suspendable;
  wire spc_any = spc_wdt || spc_low;
  wire take_spc = !busy_q && at_boundary && spc_any;
  wire take_swi = !busy_q && swi_exec && !take_spc;
  wire take_mask = !busy_q && at_boundary && !spc_any && !swi_exec &&
                   mask_ok && best_any;
  wire take_any = take_spc || take_swi || take_mask;
  wire clr_step = busy_q && (cnt_q == 5'(STEP_RD)) && !swi_q &&
                  spc_q == SPC_NONE;
  wire entry_end = busy_q && (cnt_q == ENTRY_LAST);
  wire [NUM_SRC-1:0] req_rise = src_req & ~req_d1_q;
  wire [15:0] save_word = {savepc_q[19:16], acc_lvl_q, 1'b0, tmp_q[7:0]};

  // axi write decode
  wire wr_fire = aw_have_q && w_have_q && !bv_q;
  wire [7:0] wr_off = awa_q[7:0];
  wire wr_lvl = wr_fire && wr_off == OFF_LEVEL;
  wire wr_pend = wr_fire && wr_off == OFF_PEND && ws_q[0];
  wire wr_hit = wr_off == OFF_CTRL || wr_off == OFF_LEVEL ||
                wr_off == OFF_PEND;
  wire [7:0] rd_off = s_axi_araddr[7:0];
  logic [31:0] lvl_pack;
  always_comb
  begin
    lvl_pack = 32'h0;
    for (int i = 0; i < NUM_SRC; i++)
      lvl_pack[i*4 +: 3] = lvl_q[i];
  end
  wire [31:0] rd_mux =
    rd_off == OFF_CTRL  ? {24'h0, 1'b0, ipl_q, 3'h0, flg_q[FLG_I]} :
    rd_off == OFF_LEVEL ? lvl_pack :
    rd_off == OFF_PEND  ? {24'h0, pend_q} :
    rd_off == OFF_STAT  ? {16'h0, 1'b0, num_q, 3'h0, busy_q, cnt_q} :
    rd_off == OFF_SAVE  ? {16'h0, flg_q} : 32'h0;
  wire rd_hit = rd_off <= OFF_SAVE && rd_off[1:0] == 2'h0;

  // pending flags, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q <= '0;
      req_d1_q <= '0;
    end
    else
    begin
      req_d1_q <= src_req;
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (req_rise[i])
          pend_q[i] <= 1'b1;
        else if (clr_step && src_q == 3'(i))
          pend_q[i] <= 1'b0;
        else if (wr_pend && !wd_q[i])
          pend_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int i = 0; i < NUM_SRC; i++)
        lvl_q[i] <= LVL_OFF;
    else if (wr_lvl)
      for (int i = 0; i < NUM_SRC; i++)
        if (ws_q[i/2])
          lvl_q[i] <= wd_q[i*4 +: 3];
  end

  // entry sequencer and flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flg_q <= FLG_RST;
      tmp_q <= FLG_RST;
      ipl_q <= LVL_OFF;
      acc_lvl_q <= LVL_OFF;
      cnt_q <= 5'h0;
      busy_q <= 1'b0;
      start_q <= 1'b0;
      go_q <= 1'b0;
      num_q <= 6'h0;
      swi_q <= 1'b0;
      src_q <= 3'h0;
      spc_q <= SPC_NONE;
      pc_q <= 20'h0;
      savepc_q <= 20'h0;
    end
    else
    begin
      start_q <= take_any;
      go_q <= entry_end;
      if (take_any)
      begin
        busy_q <= 1'b1;
        cnt_q <= 5'h0;
        tmp_q <= flg_q;
        savepc_q <= cur_pc;
        swi_q <= take_swi;
        src_q <= best_idx;
        spc_q <= take_spc ? (spc_wdt ? SPC_WDT : SPC_LOW) : SPC_NONE;
        num_q <= take_swi ? swi_num : {3'h0, best_idx};
        acc_lvl_q <= take_spc ? LVL_MAX : (take_swi ? ipl_q : best_lvl);
        flg_q[FLG_I] <= 1'b0;
        flg_q[FLG_D] <= 1'b0;
        if (!(take_swi && swi_num >= SWI_LO))
          flg_q[FLG_U] <= 1'b0;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q + 5'h1;
        if (cnt_q == 5'(STEP_W3) + 5'h1)
          ipl_q <= acc_lvl_q;
        if (entry_end)
        begin
          busy_q <= 1'b0;
          pc_q <= vec_pc;
        end
      end
      else if (ret_exec)
      begin
        flg_q <= ret_flags;
        ipl_q <= ret_flags[14:12];
        pc_q <= ret_pc;
      end
    end
  end

  // byte-wide stack writes: high word then pc low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bus_q <= '0;
    else
    begin
      bus_q <= '0;
      if (busy_q)
        case (cnt_q[3:0])
          STEP_RD: bus_q <= '{INFO_ADDR, 8'h0, 1'b1, 1'b0};
          STEP_W0: bus_q <= '{sp - 20'h2, save_word[7:0], 1'b0, 1'b1};
          STEP_W1: bus_q <= '{sp - 20'h1, save_word[15:8], 1'b0, 1'b1};
          STEP_W2: bus_q <= '{sp - 20'h4, savepc_q[7:0], 1'b0, 1'b1};
          STEP_W3: bus_q <= '{sp - 20'h3, savepc_q[15:8], 1'b0, 1'b1};
          default: bus_q <= '0;
        endcase
    end
  end

  // axi-lite slave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bv_q <= 1'b0;
      arr_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= '0;
      rresp_q <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        awa_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_fire)
        bv_q <= 1'b1;
      if (bv_q && s_axi_bready)
      begin
        bv_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      arr_q <= s_axi_arvalid && !arr_q && !rv_q;
      if (s_axi_arvalid && arr_q)
      begin
        rv_q <= 1'b1;
        rd_q <= rd_hit ? rd_mux : 32'h0;
        rresp_q <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (rv_q && s_axi_rready)
        rv_q <= 1'b0;
    end
  end

  logic [1:0] bresp_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bresp_q <= 2'h0;
    else if (wr_fire)
      bresp_q <= wr_hit ? 2'h0 : 2'h2;
  end

  assign entry_busy = busy_q;
  assign entry_start = start_q;
  assign routine_go = go_q;
  assign entry_num = num_q;
  assign flags = flg_q;
  assign proc_level = ipl_q;
  assign pc_load = pc_q;
  assign cpu_bus = bus_q;
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;

  // twenty busy cycles, split to keep repetitions short
  sequence entry_hold;
    busy_q [*8] ##1 busy_q [*8] ##1 busy_q [*4];
  endsequence

  a_mask_blocks: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start_q && !swi_q && spc_q == SPC_NONE |-> $past(flg_q[FLG_I]))
    else $error("accept with mask clear");
  a_level_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start_q && !swi_q && spc_q == SPC_NONE |-> acc_lvl_q > $past(ipl_q))
    else $error("level not above ipl");
  a_ipl_seven: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start_q && !swi_q && spc_q == SPC_NONE |-> $past(ipl_q) != LVL_MAX)
    else $error("ipl 7 let one in");
  a_entry_len: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(busy_q) |-> entry_hold ##1 !busy_q)
    else $error("entry length wrong");
  a_info_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(busy_q) |=> cpu_bus.rd && cpu_bus.addr == INFO_ADDR)
    else $error("no info read");
  a_flags_clr: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_any |=> !flg_q[FLG_I] && !flg_q[FLG_D])
    else $error("flags not cleared");
  a_go_after: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(busy_q) |-> go_q)
    else $error("routine start mistimed");
  a_spc_ipl: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_spc |-> ##12 ipl_q == LVL_MAX)
    else $error("special ipl");
  a_pend_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    |req_rise |=> (pend_q & $past(req_rise)) == $past(req_rise))
    else $error("request lost");
  a_pend_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clr_step && !req_rise[src_q] |=> !pend_q[src_q])
    else $error("accepted request still pending");
  a_tmp_copy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_any |=> tmp_q == $past(flg_q))
    else $error("flag copy lost");
  a_stack_keep: assert property (
    @(posedge aclk) disable iff (!aresetn)
    take_swi && swi_num >= SWI_LO |=> flg_q[FLG_U] == $past(flg_q[FLG_U]))
    else $error("stack select changed");
  a_ret_restore: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ret_exec && !busy_q && !take_any |=>
      flg_q == $past(ret_flags) && pc_q == $past(ret_pc))
    else $error("return not restored");
endmodule

// ---- bench/mipu_cpu_model.sv ----
`timescale 1ns/1ps
module mipu_cpu_model
  import mipu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic entry_busy,
  output logic instr_done,
  output logic [19:0] cur_pc
);
  logic [1:0] cnt_q;
  // instruction boundary every fourth cycle, none during entry
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 2'h0;
      instr_done <= 1'b0;
      cur_pc <= 20'h01000;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      instr_done <= (cnt_q == 2'h3) && !entry_busy;
      if (cnt_q == 2'h3)
        cur_pc <= cur_pc + 20'h00002;
    end
  end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import mipu_pkg::*;
  logic aclk, aresetn, idone, swi_exec, spc_wdt, ret_exec;
  logic [NUM_SRC-1:0] src_req;
  logic [5:0] swi_num, entry_num;
  logic [15:0] ret_flags, flags;
  logic [19:0] ret_pc, cur_pc, vec_pc, pc_load;
  logic busy, e_start, r_go, susp;
  logic [2:0] plvl;
  mipu_bus_t cbus;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int mismatches, checks_done, cyc, n, w, r;
  int unsigned seed;
  int lvl[NUM_SRC];
  mipu_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn),
    .entry_busy(busy), .instr_done(idone), .cur_pc(cur_pc));
  mipu_top u_dut (.aclk(aclk), .aresetn(aresetn), .src_req(src_req),
    .instr_done(idone), .instr_suspendable(susp), .swi_exec(swi_exec),
    .swi_num(swi_num), .spc_wdt(spc_wdt), .spc_low(1'b0),
    .ret_exec(ret_exec), .ret_flags(ret_flags), .ret_pc(ret_pc),
    .cur_pc(cur_pc), .sp(20'h00800), .vec_pc(vec_pc),
    .entry_busy(busy), .entry_start(e_start), .routine_go(r_go),
    .entry_num(entry_num), .flags(flags), .proc_level(plvl),
    .pc_load(pc_load), .cpu_bus(cbus), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic int unsigned xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // model: highest level above threshold, lowest index on ties
  function automatic int winner(input logic [7:0] p, input int processor_level_field);
    int b;
    b = -1;
    for (int i = 0; i < NUM_SRC; i++)
      if (p[i] && lvl[i] > processor_level_field && (b < 0 || lvl[i] > lvl[b]))
        b = i;
    return b;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (arvalid)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid)
      @(posedge aclk);
    d = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  initial
  begin
    seed = 71812;
    {aresetn, swi_exec, spc_wdt, ret_exec, awvalid, wvalid} = '0;
    {bready, arvalid, rready, src_req, swi_num, susp} = '0;
    {ret_flags, ret_pc, awaddr, wdata, araddr} = '0;
    vec_pc = 20'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(flags, 32'h0);
    check(plvl, 32'h0);
    axi_rd(32'h40);
    check(rresp, 32'h2);
    lvl = '{3, 5, 5, 0, 0, 0, 0, 0};
    axi_wr(OFF_LEVEL, 32'h00000553);
    axi_rd(OFF_LEVEL);
    check(d, 32'h00000553);
    src_req <= 8'h06;
    repeat (12) @(posedge aclk);
    check(busy, 32'h0);
    axi_rd(OFF_PEND);
    check(d, 32'h6);
    axi_rd(OFF_LEVEL);
    check(d, 32'h00000553);
    vec_pc <= 20'(xs());
    ret_pc <= 20'(xs());
    ret_flags <= 16'h0040;
    ret_exec <= 1'b1;
    @(posedge aclk);
    ret_exec <= 1'b0;
    while (!busy)
      @(posedge aclk);
    check(e_start, 32'h1);
    check(entry_num, 32'(winner(8'h06, 0)));
    {n, w, r} = '0;
    while (busy)
    begin
      n++;
      w += int'(cbus.wr);
      r += int'(cbus.rd && cbus.addr === INFO_ADDR);
      @(posedge aclk);
    end
    check(r_go, 32'h1);
    check(n, 32'(ENTRY_CYC));
    check(w, 32'h4);
    check(r > 0, 32'h1);
    @(posedge aclk);
    check(pc_load, 32'(vec_pc));
    check(plvl, 32'(lvl[1]));
    check(flags[FLG_I], 32'h0);
    axi_rd(OFF_PEND);
    check(d, 32'h4);
    ret_flags <= 16'h5040;
    ret_exec <= 1'b1;
    @(posedge aclk);
    ret_exec <= 1'b0;
    repeat (12) @(posedge aclk);
    check(busy, 32'(winner(8'h04, 5) >= 0));
    check(plvl, 32'h5);
    check(pc_load, 32'(ret_pc));
    axi_wr(OFF_PEND, 32'h0);
    axi_rd(OFF_PEND);
    check(d, 32'h0);
    spc_wdt <= 1'b1;
    while (!busy)
      @(posedge aclk);
    spc_wdt <= 1'b0;
    while (busy)
      @(posedge aclk);
    @(posedge aclk);
    check(plvl, 32'(LVL_MAX));
    check(flags[FLG_I], 32'h0);
    ret_flags <= 16'h00C0;
    ret_exec <= 1'b1;
    @(posedge aclk);
    ret_exec <= 1'b0;
    swi_num <= 6'h21;
    swi_exec <= 1'b1;
    @(posedge aclk);
    swi_exec <= 1'b0;
    while (!busy)
      @(posedge aclk);
    check(entry_num, 32'h21);
    while (busy)
      @(posedge aclk);
    @(posedge aclk);
    check(flags[FLG_U], 32'h1);
    check(plvl, 32'h0);
    ret_flags <= 16'h0040;
    ret_exec <= 1'b1;
    @(posedge aclk);
    ret_exec <= 1'b0;
    susp <= 1'b1;
    src_req <= 8'h07;
    repeat (3) @(posedge aclk);
    check(busy, 32'h1);
    check(entry_num, 32'(winner(8'h01, 0)));
    susp <= 1'b0;
    while (busy)
      @(posedge aclk);
    report_and_stop();
  end
endmodule
